// File: common/rqcm_pkg.sv
// Package with register map, field layout and state types of the congestion monitor.
package rqcm_pkg;

  localparam int NUM_PORTS = 16;

  // Byte addresses of port 0; port n sits at the same offset plus n times the stride, except status and mask, which decode for port 0 only.
  localparam logic [19:0] OFS_STATUS     = 20'h13000;
  localparam logic [19:0] OFS_MASK       = 20'h13004;
  localparam logic [19:0] OFS_CONG_EVENT = 20'h13090;
  localparam logic [19:0] OFS_CONG_TIME  = 20'h13094;
  localparam logic [19:0] OFS_DURATION   = 20'h13098;
  localparam logic [19:0] OFS_REORDER    = 20'h130a0;
  localparam logic [19:0] PORT_STRIDE    = 20'h00100;

  // Field positions.
  localparam int LIMIT_LSB    = 16;
  localparam int DUR_PER_LSB  = 16;
  localparam int DUR_MODE_BIT = 31;
  localparam int REO_FLAG_LSB = 16;

  // Values after reset.
  localparam logic [31:0] DURATION_RST = 32'h00000000;
  localparam logic [31:0] REORDER_RST  = 32'h0000ffff;
  localparam logic [15:0] EVT_LIM_RST  = 16'h0000;
  localparam logic [31:0] MASK_RST     = 32'h00000000;

  // Counter ceilings and the period stretch of duration mode one.
  localparam logic [15:0] CNT16_MAX       = 16'hffff;
  localparam logic [31:0] CNT32_MAX       = 32'hffffffff;
  localparam int          MODE1_PER_SHIFT = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    RQCM_REG_NONE,
    RQCM_REG_STATUS,
    RQCM_REG_MASK,
    RQCM_REG_CONG_EVENT,
    RQCM_REG_CONG_TIME,
    RQCM_REG_DURATION,
    RQCM_REG_REORDER
  } rqcm_reg_t;

  typedef struct packed {
    rqcm_reg_t  kind;
    logic [3:0] port;
  } rqcm_dec_t;

  // Per-port event inputs from the receive queue and the fabric.
  typedef struct packed {
    logic [NUM_PORTS-1:0] congested;
    logic [NUM_PORTS-1:0] packet_received;
    logic [NUM_PORTS-1:0] reorder_event;
  } rqcm_rx_ev_t;

  typedef struct packed {
    logic [15:0] congestion_event_count;
    logic [15:0] congestion_event_limit;
    logic [15:0] leak_period;
    logic [15:0] leak_pre;
    logic [14:0] duration_tick_period;
    logic        duration_mode;
    logic [19:0] duration_pre;
    logic [31:0] duration_word;
    logic [15:0] reorder_tally;
    logic [15:0] reorder_limit;
  } rqcm_port_t;

  typedef struct packed {
    rqcm_port_t [NUM_PORTS-1:0] port;
    logic [31:0]                status;
    logic [31:0]                mask;
    logic                       aw_full;
    logic                       w_full;
    logic [19:0]                awaddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       irq;
  } rqcm_state_t;

endpackage : rqcm_pkg

// File: verilog/rqcm_monitor.sv
// Receive queue congestion and reorder monitor for sixteen ports with an AXI4-Lite slave.
// Overview of operation
// - Event count reaching limit sets congestion flag.
// - Zero event limit disables event counting.
// - Count packets while congested, saturate 0xFFFF.
// - Writing one to congestion flag clears count.
// - Leak period expiry decrements, floor zero.
// - Mode zero: both fields form 32-bit counter.
// - Mode one: only 16-bit count advances.
// - Duration counter saturates instead of wrapping.
// - Zero duration period disables duration counter.
// - Mode zero: reading duration register clears it.
// - Mode one: count reaching limit sets flag.
// - Mode one: flag clear also clears count.
// - Mode zero: upper field is upper count half.
// - Software writes load the duration counter.
// - Reorder tally counts out-of-order fabric service.
// - Reorder tally saturates; flag clear zeroes it.
// - Reorder tally equal limit raises reorder flag.
// - Zero reorder limit disables; reset limit 0xFFFF.
//
// Our own choice: the AXI4-Lite slave port.
module rqcm_monitor
  import rqcm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [19:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [19:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire rqcm_rx_ev_t rx_ev,
  output logic             irq
);

  function automatic rqcm_dec_t decode(input logic [19:0] addr);
    rqcm_dec_t   r;
    logic [19:0] base;
    r.port = addr[11:8];
    r.kind = RQCM_REG_NONE;
    base   = {addr[19:12], 4'h0, addr[7:2], 2'b00};
    if (base == OFS_CONG_EVENT)
      r.kind = RQCM_REG_CONG_EVENT;
    else if (base == OFS_CONG_TIME)
      r.kind = RQCM_REG_CONG_TIME;
    else if (base == OFS_DURATION)
      r.kind = RQCM_REG_DURATION;
    else if (base == OFS_REORDER)
      r.kind = RQCM_REG_REORDER;
    else if (base == OFS_STATUS && r.port == 4'h0)
      r.kind = RQCM_REG_STATUS;
    else if (base == OFS_MASK && r.port == 4'h0)
      r.kind = RQCM_REG_MASK;
    return r;
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = val[8*b +: 8];
    end
    return r;
  endfunction : merge

  rqcm_state_t          q;
  rqcm_state_t          d;
  rqcm_dec_t            wdec;
  rqcm_dec_t            rdec;
  logic                 wr_go;
  logic                 rd_go;
  logic [31:0]          w1c;
  logic [NUM_PORTS-1:0] inb_set;
  logic [NUM_PORTS-1:0] reo_set;

  assign wr_go = q.aw_full && q.w_full && !q.bvalid;
  assign rd_go = q.arready && arvalid;
  assign wdec  = decode(q.awaddr);
  assign rdec  = decode(araddr);
  assign w1c   = (wr_go && wdec.kind == RQCM_REG_STATUS) ? merge(32'h0, q.wdata, q.wstrb) : 32'h0;

  always_comb
  begin
    logic [19:0] per_eff;
    logic        leak_tick;
    logic        evt_inc;
    logic        evt_dec;
    logic        dur_tick;
    logic        port_wr;
    logic        port_rd;
    logic [31:0] merged;
    d         = q;
    inb_set   = '0;
    reo_set   = '0;
    per_eff   = 20'h0;
    leak_tick = 1'b0;
    evt_inc   = 1'b0;
    evt_dec   = 1'b0;
    dur_tick  = 1'b0;
    port_wr   = 1'b0;
    port_rd   = 1'b0;
    merged    = 32'h0;

    for (int p = 0; p < NUM_PORTS; p++)
    begin
      port_wr = wr_go && wdec.port == 4'(p);
      port_rd = rd_go && rdec.port == 4'(p);

      // Leak prescaler counts clock cycles; it idles while the event counter is disabled.
      leak_tick = 1'b0;
      if (q.port[p].leak_period == 16'h0 || q.port[p].congestion_event_limit == 16'h0)
        d.port[p].leak_pre = 16'h0;
      else if (q.port[p].leak_pre >= q.port[p].leak_period - 16'h1)
      begin
        d.port[p].leak_pre = 16'h0;
        leak_tick          = 1'b1;
      end
      else
        d.port[p].leak_pre = q.port[p].leak_pre + 16'h1;

      evt_inc = q.port[p].congestion_event_limit != 16'h0 && rx_ev.congested[p]
                && rx_ev.packet_received[p] && q.port[p].congestion_event_count != CNT16_MAX;
      evt_dec = leak_tick && q.port[p].congestion_event_count != 16'h0;
      if (evt_inc && !evt_dec)
        d.port[p].congestion_event_count = q.port[p].congestion_event_count + 16'h1;
      else if (evt_dec && !evt_inc)
        d.port[p].congestion_event_count = q.port[p].congestion_event_count - 16'h1;
      if (w1c[p])
        d.port[p].congestion_event_count = 16'h0;

      // The duration prescaler restarts whenever congestion lapses, so only unbroken
      // congestion produces ticks.
      per_eff = q.port[p].duration_mode
              ? {1'b0, q.port[p].duration_tick_period, 4'h0}
              : {5'h0, q.port[p].duration_tick_period};
      dur_tick = 1'b0;
      if (q.port[p].duration_tick_period == 15'h0 || !rx_ev.congested[p])
        d.port[p].duration_pre = 20'h0;
      else if (q.port[p].duration_pre >= per_eff - 20'h1)
      begin
        d.port[p].duration_pre = 20'h0;
        dur_tick               = 1'b1;
      end
      else
        d.port[p].duration_pre = q.port[p].duration_pre + 20'h1;

      if (dur_tick && !q.port[p].duration_mode && q.port[p].duration_word != CNT32_MAX)
        d.port[p].duration_word = q.port[p].duration_word + 32'h1;
      if (dur_tick && q.port[p].duration_mode && q.port[p].duration_word[15:0] != CNT16_MAX)
        d.port[p].duration_word[15:0] = q.port[p].duration_word[15:0] + 16'h1;
      if (q.port[p].duration_mode && w1c[p])
        d.port[p].duration_word[15:0] = 16'h0;
      if (!q.port[p].duration_mode && port_rd && rdec.kind == RQCM_REG_DURATION)
        d.port[p].duration_word = 32'h0;
      if (port_wr && wdec.kind == RQCM_REG_DURATION)
        d.port[p].duration_word = merge(q.port[p].duration_word, q.wdata, q.wstrb);

      if (q.port[p].reorder_limit != 16'h0 && rx_ev.reorder_event[p]
          && q.port[p].reorder_tally != CNT16_MAX)
        d.port[p].reorder_tally = q.port[p].reorder_tally + 16'h1;
      if (w1c[REO_FLAG_LSB + p])
        d.port[p].reorder_tally = 16'h0;
      // The limit sits in the low half, so the reset word leaves the tally enabled.
      if (port_wr && wdec.kind == RQCM_REG_REORDER)
        {d.port[p].reorder_tally, d.port[p].reorder_limit} =
          merge({q.port[p].reorder_tally, q.port[p].reorder_limit}, q.wdata, q.wstrb);

      if (port_wr && wdec.kind == RQCM_REG_CONG_EVENT)
      begin
        merged                           = merge({q.port[p].congestion_event_limit, 16'h0},
                                                 q.wdata, q.wstrb);
        d.port[p].congestion_event_limit = merged[31:LIMIT_LSB];
      end
      if (port_wr && wdec.kind == RQCM_REG_CONG_TIME)
        {d.port[p].duration_mode, d.port[p].duration_tick_period, d.port[p].leak_period} =
          merge({q.port[p].duration_mode, q.port[p].duration_tick_period,
                 q.port[p].leak_period}, q.wdata, q.wstrb);

      // Equality is judged on the new value against the old one so that a count that
      // merely rests on the limit does not set the flag again after software clears it.
      // The duration flag looks at the new count, so a clear that zeroes it is not undone.
      inb_set[p] = (q.port[p].congestion_event_limit != 16'h0
                    && d.port[p].congestion_event_count == q.port[p].congestion_event_limit
                    && q.port[p].congestion_event_count != q.port[p].congestion_event_limit)
                 || (q.port[p].duration_mode && q.port[p].duration_tick_period != 15'h0
                    && d.port[p].duration_word[15:0] >= d.port[p].duration_word[31:16]);
      reo_set[p] = q.port[p].reorder_limit != 16'h0
                   && d.port[p].reorder_tally == q.port[p].reorder_limit
                   && q.port[p].reorder_tally != q.port[p].reorder_limit;
    end

    // A flag raised in the cycle of its clear stays set.
    d.status = (q.status & ~w1c) | {reo_set, inb_set};
    if (wr_go && wdec.kind == RQCM_REG_MASK)
      d.mask = merge(q.mask, q.wdata, q.wstrb);
    d.irq = |(d.status & d.mask);

    // Write channel: address and data are caught in either order; a new pair is
    // refused until the response has been taken, which keeps one write in flight.
    if (q.awready && awvalid)
    begin
      d.aw_full = 1'b1;
      d.awaddr  = awaddr;
    end
    if (q.wready && wvalid)
    begin
      d.w_full = 1'b1;
      d.wdata  = wdata;
      d.wstrb  = wstrb;
    end
    if (wr_go)
    begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wdec.kind == RQCM_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (q.bvalid && bready)
      d.bvalid = 1'b0;
    d.awready = !d.aw_full && !d.bvalid && !wr_go;
    d.wready  = !d.w_full && !d.bvalid && !wr_go;

    // Read channel: data is captured at the edge that takes the address.
    if (rd_go)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      unique case (rdec.kind)
        RQCM_REG_STATUS:
          d.rdata = q.status;
        RQCM_REG_MASK:
          d.rdata = q.mask;
        RQCM_REG_CONG_EVENT:
          d.rdata = {q.port[rdec.port].congestion_event_limit,
                     q.port[rdec.port].congestion_event_count};
        RQCM_REG_CONG_TIME:
          d.rdata = {q.port[rdec.port].duration_mode, q.port[rdec.port].duration_tick_period,
                     q.port[rdec.port].leak_period};
        RQCM_REG_DURATION:
          d.rdata = q.port[rdec.port].duration_word;
        RQCM_REG_REORDER:
          d.rdata = {q.port[rdec.port].reorder_tally, q.port[rdec.port].reorder_limit};
        RQCM_REG_NONE:
        begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (q.rvalid && rready)
      d.rvalid = 1'b0;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q         <= '0;
      q.mask    <= MASK_RST;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        q.port[p].congestion_event_limit              <= EVT_LIM_RST;
        q.port[p].duration_word                       <= DURATION_RST;
        {q.port[p].reorder_tally, q.port[p].reorder_limit} <= REORDER_RST;
      end
    end
    else
      q <= d;
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arready;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign irq     = q.irq;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  evt_limit_flag_a : assert property (
    (q.port[0].congestion_event_limit != 16'h0
     && d.port[0].congestion_event_count == q.port[0].congestion_event_limit
     && q.port[0].congestion_event_count != q.port[0].congestion_event_limit) |=> q.status[0])
    else $error("Congestion flag not set when count met limit.");

  evt_disabled_a : assert property (
    (q.port[0].congestion_event_limit == 16'h0 && !w1c[0]) |=>
      $stable(q.port[0].congestion_event_count))
    else $error("Congestion event count moved while disabled.");

  evt_saturate_a : assert property (
    (q.port[0].congestion_event_count == CNT16_MAX && rx_ev.congested[0]
     && rx_ev.packet_received[0] && q.port[0].leak_period == 16'h0 && !w1c[0]) |=>
      q.port[0].congestion_event_count == CNT16_MAX)
    else $error("Congestion event count left its ceiling.");

  evt_clear_a : assert property (
    w1c[0] |=> q.port[0].congestion_event_count == 16'h0)
    else $error("Congestion event count not cleared by flag write.");

  dur_wrap_a : assert property (
    (q.port[0].duration_word == CNT32_MAX && !q.port[0].duration_mode && !wr_go && !rd_go) |=>
      q.port[0].duration_word == CNT32_MAX)
    else $error("Duration counter wrapped.");

  dur_disabled_a : assert property (
    (q.port[0].duration_tick_period == 15'h0 && !wr_go && !rd_go && !w1c[0]) |=>
      $stable(q.port[0].duration_word))
    else $error("Duration counter advanced with zero period.");

  dur_read_clear_a : assert property (
    (rd_go && rdec.port == 4'h0 && rdec.kind == RQCM_REG_DURATION
     && !q.port[0].duration_mode && !wr_go) |=> rdata == $past(q.port[0].duration_word)
      && q.port[0].duration_word == 32'h0)
    else $error("Duration read did not return and clear the counter.");

  reo_limit_flag_a : assert property (
    (q.port[0].reorder_limit != 16'h0 && rx_ev.reorder_event[0] && !w1c[REO_FLAG_LSB]
     && !wr_go && q.port[0].reorder_tally == q.port[0].reorder_limit - 16'h1) |=>
      q.status[REO_FLAG_LSB] && q.port[0].reorder_tally == q.port[0].reorder_limit)
    else $error("Reorder flag not raised at limit.");

  reo_disabled_a : assert property (
    (q.port[0].reorder_limit == 16'h0 && !wr_go && !w1c[REO_FLAG_LSB]) |=>
      $stable(q.port[0].reorder_tally))
    else $error("Reorder tally moved while disabled.");

  irq_follow_a : assert property (
    ##1 irq == |($past(d.status) & $past(d.mask)))
    else $error("Interrupt output does not track masked status.");

  write_resp_a : assert property (
    wr_go |=> bvalid)
    else $error("Write response missing after the write executed.");

  write_hold_a : assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("Write response dropped before it was taken.");

  read_hold_a : assert property (
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read response dropped before it was taken.");

  dur_limit_flag_a : assert property (
    (q.port[0].duration_mode && q.port[0].duration_tick_period != 15'h0 && !w1c[0] && !wr_go
     && q.port[0].duration_word[15:0] >= q.port[0].duration_word[31:16]) |=> q.status[0])
    else $error("Duration flag not set at its limit.");

  dur_flag_clear_a : assert property (
    (q.port[0].duration_mode && w1c[0]) |=> q.port[0].duration_word[15:0] == 16'h0)
    else $error("Duration count not cleared with its flag.");

  reo_clear_a : assert property (
    w1c[REO_FLAG_LSB] |=> q.port[0].reorder_tally == 16'h0)
    else $error("Reorder tally not cleared by flag write.");

endmodule : rqcm_monitor

// File: bench/rqcm_testbench.sv
// Self-checking bench for the receive queue congestion and reorder monitor.
module testbench
  import rqcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk;
  logic        aresetn;
  logic [19:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [19:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  rqcm_rx_ev_t rx_ev;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          seed;
  int          errors;
  int          cmp_count;
  int          p;
  int          q;
  int          k;
  int          n;

  rqcm_monitor rqcm_monitor_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rx_ev   (rx_ev),
    .irq     (irq)
  );

  always #20 aclk = ~aclk;

  function automatic logic [19:0] port_addr(input logic [19:0] ofs, input int pn);
    return ofs + PORT_STRIDE * 20'(pn);
  endfunction : port_addr

  function automatic logic [31:0] pair(input int hi, input int lo);
    return {16'(hi), 16'(lo)};
  endfunction : pair

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  // Address and data go out together; each is dropped only at its own handshake edge.
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    // A random stall before ready makes the slave hold its answer.
    repeat ($random(seed) & 3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [19:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($random(seed) & 3) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // Each pulse is followed by an idle cycle so every event is a clean one-cycle strobe.
  task automatic pulse(input int kind, input int pn, input int cnt);
    repeat (cnt)
    begin
      if (kind == 0)
        rx_ev.packet_received[pn] <= 1'b1;
      else
        rx_ev.reorder_event[pn] <= 1'b1;
      @(posedge aclk);
      rx_ev.packet_received[pn] <= 1'b0;
      rx_ev.reorder_event[pn] <= 1'b0;
      @(posedge aclk);
    end
  endtask : pulse

  task automatic congest(input int pn, input int cyc);
    rx_ev.congested[pn] <= 1'b1;
    repeat (cyc) @(posedge aclk);
    rx_ev.congested[pn] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : congest

  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("unexpected watchdog expected finish seen hang");
    complete_run();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    rx_ev = '0;
    seed = 50518;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Port 0 carries the main scenarios so its assertions see traffic; q is another port.
    p = 0;
    q = 1 + (($random(seed) & 32'h7fffffff) % 15);
    k = 4 + ($random(seed) & 7);
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder reset", REORDER_RST, rd);
    pulse(1, p, 1);
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder counts from reset", REORDER_RST + 32'h00010000, rd);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration reset", DURATION_RST, rd);
    rd_reg(OFS_MASK);
    check("mask reset", MASK_RST, rd);
    rd_reg(20'h12000);
    check("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    check("unmapped read data", 32'h00000000, rd);
    wr(20'h12000, 32'h12345678);
    check("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    end_test("reset and map");

    wr(port_addr(OFS_CONG_EVENT, p), pair(k, 0));
    rx_ev.congested[p] <= 1'b1;
    rx_ev.congested[q] <= 1'b1;
    pulse(0, p, k);
    pulse(0, q, 3);
    rd_reg(port_addr(OFS_CONG_EVENT, p));
    check("event count", pair(k, k), rd);
    rd_reg(port_addr(OFS_CONG_EVENT, q));
    check("event count zero limit", 32'h00000000, rd);
    rd_reg(OFS_STATUS);
    check("event flag", 32'h1 << p, rd);
    wr(OFS_MASK, 32'h1 << p);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFS_MASK, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    rx_ev.congested[p] <= 1'b0;
    rx_ev.congested[q] <= 1'b0;
    pulse(0, p, 2);
    rd_reg(port_addr(OFS_CONG_EVENT, p));
    check("event count idle queue", pair(k, k), rd);
    wr(OFS_STATUS, 32'h1 << p);
    rd_reg(port_addr(OFS_CONG_EVENT, p));
    check("event count cleared", pair(k, 0), rd);
    rd_reg(OFS_STATUS);
    check("event flag cleared", 32'h0, rd);
    rx_ev.congested[p] <= 1'b1;
    pulse(0, p, 3);
    rx_ev.congested[p] <= 1'b0;
    wr(port_addr(OFS_CONG_TIME, p), 32'h00000006);
    repeat (60) @(posedge aclk);
    rd_reg(port_addr(OFS_CONG_EVENT, p));
    check("event count leaked", pair(k, 0), rd);
    wr(port_addr(OFS_CONG_TIME, p), 32'h0);
    end_test("event counter");

    // Congestion spans leave a four-cycle margin around each expected tick.
    wr(port_addr(OFS_CONG_TIME, p), 32'h00080000);
    wr(port_addr(OFS_DURATION, p), 32'h0000ffff);
    congest(p, 20);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 32 carry", 32'h00010001, rd);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration read clear", 32'h00000000, rd);
    wr(port_addr(OFS_DURATION, p), 32'hffffffff);
    congest(p, 20);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 32 ceiling", 32'hffffffff, rd);
    wr(port_addr(OFS_CONG_TIME, p), 32'h0);
    wr(port_addr(OFS_DURATION, p), 32'h00000005);
    congest(p, 20);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration period off", 32'h00000005, rd);
    end_test("duration mode zero");

    wr(port_addr(OFS_CONG_TIME, p), 32'h80010000);
    wr(port_addr(OFS_DURATION, p), 32'h00020000);
    congest(p, 36);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 16 count", 32'h00020002, rd);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 16 kept on read", 32'h00020002, rd);
    rd_reg(OFS_STATUS);
    check("duration flag", 32'h1 << p, rd);
    wr(OFS_STATUS, 32'h1 << p);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 16 cleared", 32'h00020000, rd);
    rd_reg(OFS_STATUS);
    check("duration flag cleared", 32'h0, rd);
    wr(port_addr(OFS_DURATION, p), 32'h0005ffff);
    congest(p, 20);
    rd_reg(port_addr(OFS_DURATION, p));
    check("duration 16 ceiling", 32'h0005ffff, rd);
    wr(port_addr(OFS_CONG_TIME, p), 32'h0);
    wr(OFS_STATUS, 32'hffffffff);
    end_test("duration mode one");

    wr(port_addr(OFS_REORDER, p), pair(0, k));
    pulse(1, p, k);
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder tally", pair(k, k), rd);
    rd_reg(OFS_STATUS);
    check("reorder flag", 32'h1 << (REO_FLAG_LSB + p), rd);
    wr(OFS_MASK, 32'h1 << (REO_FLAG_LSB + p));
    check("irq reorder", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 32'h1 << (REO_FLAG_LSB + p));
    check("irq after clear", 32'h0, {31'h0, irq});
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder cleared", pair(0, k), rd);
    wr(port_addr(OFS_REORDER, p), 32'hfffeffff);
    pulse(1, p, 3);
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder ceiling", 32'hffffffff, rd);
    wr(port_addr(OFS_REORDER, p), 32'h0);
    pulse(1, p, 2);
    rd_reg(port_addr(OFS_REORDER, p));
    check("reorder zero limit", 32'h0, rd);
    for (int i = 0; i < 4; i++)
    begin
      q = $random(seed) & 15;
      n = 1 + ($random(seed) & 7);
      wr(port_addr(OFS_REORDER, q), 32'h000000ff);
      pulse(1, q, n);
      rd_reg(port_addr(OFS_REORDER, q));
      check("reorder random port", pair(n, 255), rd);
    end
    end_test("reorder counter");
    complete_run();
  end

endmodule : testbench
